//--- include/itq_map.svh
// register offsets, field positions, reset values of the trace qualifier
// assumes byte addressing on a 32-bit avalon-mm slave, one word per register
`ifndef ITQ_MAP_SVH
`define ITQ_MAP_SVH
`define ITQ_OFS_CTRL    6'h00
`define ITQ_OFS_ADDR1   6'h04
`define ITQ_OFS_ADDR2   6'h08
`define ITQ_OFS_AMASK   6'h0C
`define ITQ_OFS_DCMP    6'h10
`define ITQ_OFS_PCMP    6'h14
`define ITQ_OFS_COUNT   6'h18
`define ITQ_OFS_OPRANGE 6'h1C
`define ITQ_OFS_STATUS  6'h20
`define ITQ_CTRL_MODE   0
`define ITQ_CTRL_OPC    1
`define ITQ_CTRL_MEMQ   2
`define ITQ_CTRL_IOQ    4
`define ITQ_CTRL_RANGE  5
`define ITQ_CTRL_EXT8   6
`define ITQ_STAT_DONE   16
`define ITQ_CFG_RESET   '0
`define ITQ_WAIT_RESET  1'b1
`endif

//--- include/itq_pkg.sv
// types of the instruction trace qualifier
// assumes itq_map.svh supplies the offsets and reset values
package itq_pkg;
  typedef enum logic [1:0] {
    ITQ_FETCH = 2'b00,
    ITQ_MEMRD = 2'b01,
    ITQ_MEMWR = 2'b10,
    ITQ_IO    = 2'b11
  } itq_cyc_t;
  typedef enum logic [1:0] {
    ITQ_MQ_OFF = 2'b00,
    ITQ_MQ_ANY = 2'b01,
    ITQ_MQ_RD  = 2'b10,
    ITQ_MQ_WR  = 2'b11
  } itq_memq_t;
  typedef enum logic [1:0] {
    ITQ_PH_IDLE   = 2'b00,
    ITQ_PH_FOLLOW = 2'b01,
    ITQ_PH_DONE   = 2'b10
  } itq_phase_t;
  typedef struct packed {
    itq_cyc_t    cycType;
    logic [7:0]  extQual;
    logic [23:0] addr;
    logic [15:0] data;
    logic [7:0]  probe;
    logic        sioOut;
    logic        sioIn;
  } itq_bus_t;
  typedef struct packed {
    itq_cyc_t    cycType;
    logic [7:0]  extQual;
    logic [23:0] addr;
    logic [15:0] data;
  } itq_sample_t;
  typedef struct packed {
    logic        extMode;
    logic        opcEn;
    itq_memq_t   memQual;
    logic        ioAll;
    logic        rangeEn;
    logic        ext8;
    logic [23:0] addr1;
    logic [23:0] addr2;
    logic [15:0] addrMask;
    logic [15:0] cmpWord;
    logic [15:0] cmpMask;
    logic [7:0]  probeByte;
    logic [7:0]  probeMask;
    logic [10:0] countLim;
    logic [15:0] opLo;
    logic [15:0] opHi;
  } itq_cfg_t;
  typedef struct packed {
    itq_bus_t    syn1;
    itq_bus_t    syn2;
    logic        stb1;
    logic        stb2;
    logic        stb3;
    itq_cfg_t    cfg;
    itq_phase_t  phase;
    logic [10:0] sampleCnt;
    logic        waitReq;
    logic [31:0] rdData;
    logic        sampleValid;
    itq_sample_t sample;
    logic        traceDone;
  } itq_state_t;
endpackage

//--- rtl/itq_qualifier.sv
// extended instruction-fetch trace qualifier with avalon-mm register slave
// assumes target bus pins are asynchronous and stable while tgtCycle is high
// Notes on behaviour
// (RULE_01) in extended mode only fetches decide; later cycles follow that decision
// (RULE_02) fetch qualifies when opcode, address, data and probe checks all pass
// (RULE_03) opcode enable limits qualifying fetches to the programmed opcode range
// (RULE_04) memory qualifier: 0 none, 1 all, 2 reads, 3 writes
// (RULE_05) reads setting records only reads; none records no memory cycle
// (RULE_06) i/o qualifier 1 records every i/o cycle of the instruction, 0 none
// (RULE_07) two compare addresses, 16 bits or 24 with extended bits
// (RULE_08) range off: address matches either compare value
// (RULE_09) range on, first below second: inclusive window passes
// (RULE_10) range on, first above second: strictly between is rejected
// (RULE_11) software loads both values equal with range off for one address
// (RULE_12) data bus must equal compare word on masked bits
// (RULE_13) zero mask bits are ignored; zero mask matches anything
// (RULE_14) probe byte compared under mask; forced zero with extended bits
// (RULE_15) trace mode bit: 0 combined mode, 1 extended fetch mode; the code records nothing at 0
// (RULE_16) count 1 to 2047 stops tracing; zero runs forever
// (RULE_17) 16-bit ones-enable mask selects compared address bits
// (RULE_18) i/o samples hold only serial out and serial in bits
// (RULE_19) all settings clear to zero at reset
// (RULE_20) sample stores cycle type, qualifier lines, address and data
`timescale 1ns/1ps
`include "itq_map.svh"
module itq_qualifier (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [5:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [31:0]      writedata,
  input  wire logic [3:0]       byteenable,
  output logic [31:0]           readdata,
  output logic                  waitrequest,
  input  wire logic             tgtCycle,
  input  wire itq_pkg::itq_bus_t tgtBus,
  output logic                  sampleValid,
  output itq_pkg::itq_sample_t  sample,
  output logic                  traceDone
);
  itq_pkg::itq_state_t q;
  itq_pkg::itq_state_t d;
  logic [31:0] regView;
  logic [31:0] byteMask;
  logic [31:0] merged;
  logic        cycEdge;
  logic        isFetch;
  logic [23:0] effMask;
  logic [23:0] ma;
  logic [23:0] a1;
  logic [23:0] a2;
  logic        addrOk;
  logic        dataOk;
  logic        probeOk;
  logic        opOk;
  logic        fetchOk;
  logic        followOk;
  logic        limitHit;

  // edge taken from the second and third stages, first stage stays private
  assign cycEdge = q.stb2 & ~q.stb3;
  assign isFetch = (q.syn2.cycType == itq_pkg::ITQ_FETCH);

  // (RULE_17) address mask select
  // extended bits always compared; without them the top byte is don't-care
  assign effMask = {(q.cfg.ext8 ? 8'hFF : 8'h00), q.cfg.addrMask};
  // (RULE_07) compare value width
  assign ma = q.syn2.addr & effMask;
  assign a1 = q.cfg.addr1 & effMask;
  assign a2 = q.cfg.addr2 & effMask;

  always_comb begin
    if (!q.cfg.rangeEn) begin
      // (RULE_08) either address match
      addrOk = (ma == a1) || (ma == a2);
    end else if (a1 <= a2) begin
      // (RULE_09) inclusive window
      addrOk = (ma >= a1) && (ma <= a2);
    end else begin
      // (RULE_10) outside window passes
      addrOk = !((ma > a2) && (ma < a1));
    end
  end

  // (RULE_12) masked data compare
  // (RULE_13) zero bits ignored
  assign dataOk = ((q.syn2.data ^ q.cfg.cmpWord) & q.cfg.cmpMask) == 16'h0000;
  // (RULE_14) probe check, forced open
  assign probeOk = q.cfg.ext8 ||
                   (((q.syn2.probe ^ q.cfg.probeByte) & q.cfg.probeMask) == 8'h00);
  // (RULE_03) opcode range gate
  assign opOk = !q.cfg.opcEn ||
                ((q.syn2.data >= q.cfg.opLo) && (q.syn2.data <= q.cfg.opHi));
  // (RULE_02) all checks together
  assign fetchOk = opOk && addrOk && probeOk && dataOk;

  always_comb begin
    unique case (q.syn2.cycType)
      // (RULE_05) reads only or none
      // (RULE_04) memory qualifier decode
      itq_pkg::ITQ_MEMRD: followOk = (q.cfg.memQual == itq_pkg::ITQ_MQ_ANY) ||
                                     (q.cfg.memQual == itq_pkg::ITQ_MQ_RD);
      itq_pkg::ITQ_MEMWR: followOk = (q.cfg.memQual == itq_pkg::ITQ_MQ_ANY) ||
                                     (q.cfg.memQual == itq_pkg::ITQ_MQ_WR);
      // (RULE_06) all i/o or none
      itq_pkg::ITQ_IO:    followOk = q.cfg.ioAll;
      itq_pkg::ITQ_FETCH: followOk = 1'b0;
    endcase
  end

  // (RULE_16) stop at programmed count
  assign limitHit = (q.cfg.countLim != 11'h000) &&
                    ((q.sampleCnt + 11'h001) == q.cfg.countLim);

  always_comb begin
    regView = 32'h0000_0000;
    case (address)
      `ITQ_OFS_CTRL: begin
        regView[`ITQ_CTRL_MODE]        = q.cfg.extMode;
        regView[`ITQ_CTRL_OPC]         = q.cfg.opcEn;
        regView[`ITQ_CTRL_MEMQ +: 2]   = q.cfg.memQual;
        regView[`ITQ_CTRL_IOQ]         = q.cfg.ioAll;
        regView[`ITQ_CTRL_RANGE]       = q.cfg.rangeEn;
        regView[`ITQ_CTRL_EXT8]        = q.cfg.ext8;
      end
      `ITQ_OFS_ADDR1:   regView = {8'h00, q.cfg.addr1};
      `ITQ_OFS_ADDR2:   regView = {8'h00, q.cfg.addr2};
      `ITQ_OFS_AMASK:   regView = {16'h0000, q.cfg.addrMask};
      `ITQ_OFS_DCMP:    regView = {q.cfg.cmpMask, q.cfg.cmpWord};
      `ITQ_OFS_PCMP:    regView = {16'h0000, q.cfg.probeMask, q.cfg.probeByte};
      `ITQ_OFS_COUNT:   regView = {21'h000000, q.cfg.countLim};
      `ITQ_OFS_OPRANGE: regView = {q.cfg.opHi, q.cfg.opLo};
      `ITQ_OFS_STATUS: begin
        regView[10:0]           = q.sampleCnt;
        regView[`ITQ_STAT_DONE] = (q.phase == itq_pkg::ITQ_PH_DONE);
      end
      default:          regView = 32'h0000_0000;
    endcase
  end

  assign byteMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};
  assign merged   = (regView & ~byteMask) | (writedata & byteMask);

  always_comb begin
    d             = q;
    d.syn1        = tgtBus;
    d.syn2        = q.syn1;
    d.stb1        = tgtCycle;
    d.stb2        = q.stb1;
    d.stb3        = q.stb2;
    d.sampleValid = 1'b0;
    d.waitReq     = 1'b1;
    // one wait cycle, then answer; write lands on the answer edge
    if ((read || write) && q.waitReq) begin
      d.waitReq = 1'b0;
      d.rdData  = regView;
    end
    // extended-mode qualification
    if (cycEdge && q.cfg.extMode && (q.phase != itq_pkg::ITQ_PH_DONE)) begin
      d.sample.cycType = q.syn2.cycType;
      d.sample.extQual = q.syn2.extQual;
      d.sample.addr    = q.syn2.addr;
      d.sample.data    = q.syn2.data;
      // (RULE_18) serial bits only
      if (q.syn2.cycType == itq_pkg::ITQ_IO) begin
        d.sample.data = {14'h0000, q.syn2.sioOut, q.syn2.sioIn};
      end
      // (RULE_01) fetch decides instruction
      if (isFetch) begin
        d.phase = fetchOk ? itq_pkg::ITQ_PH_FOLLOW : itq_pkg::ITQ_PH_IDLE;
      end
      // (RULE_20) record whole sample
      if ((isFetch && fetchOk) ||
          (!isFetch && (q.phase == itq_pkg::ITQ_PH_FOLLOW) && followOk)) begin
        d.sampleValid = 1'b1;
        d.sampleCnt   = q.sampleCnt + 11'h001;
        if (limitHit) begin
          d.phase = itq_pkg::ITQ_PH_DONE;
        end
      end
    end
    // software write; a control write also rearms the count
    if (write && !q.waitReq) begin
      case (address)
        `ITQ_OFS_CTRL: begin
          // (RULE_15) trace mode select
          d.cfg.extMode = merged[`ITQ_CTRL_MODE];
          d.cfg.opcEn   = merged[`ITQ_CTRL_OPC];
          d.cfg.memQual = itq_pkg::itq_memq_t'(merged[`ITQ_CTRL_MEMQ +: 2]);
          d.cfg.ioAll   = merged[`ITQ_CTRL_IOQ];
          d.cfg.rangeEn = merged[`ITQ_CTRL_RANGE];
          d.cfg.ext8    = merged[`ITQ_CTRL_EXT8];
          d.sampleCnt   = 11'h000;
          d.phase       = itq_pkg::ITQ_PH_IDLE;
          d.sampleValid = 1'b0;
        end
        `ITQ_OFS_ADDR1:   d.cfg.addr1    = merged[23:0];
        `ITQ_OFS_ADDR2:   d.cfg.addr2    = merged[23:0];
        `ITQ_OFS_AMASK:   d.cfg.addrMask = merged[15:0];
        `ITQ_OFS_DCMP: begin
          d.cfg.cmpWord = merged[15:0];
          d.cfg.cmpMask = merged[31:16];
        end
        `ITQ_OFS_PCMP: begin
          d.cfg.probeByte = merged[7:0];
          d.cfg.probeMask = merged[15:8];
        end
        `ITQ_OFS_COUNT:   d.cfg.countLim = merged[10:0];
        `ITQ_OFS_OPRANGE: begin
          d.cfg.opLo = merged[15:0];
          d.cfg.opHi = merged[31:16];
        end
        default: ;
      endcase
    end
    // (RULE_14) probe settings cleared
    if (d.cfg.ext8) begin
      d.cfg.probeByte = 8'h00;
      d.cfg.probeMask = 8'h00;
    end
    d.traceDone = (d.phase == itq_pkg::ITQ_PH_DONE);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // (RULE_19) settings cleared
      q         <= `ITQ_CFG_RESET;
      q.waitReq <= `ITQ_WAIT_RESET;
    end else begin
      q <= d;
    end
  end

  assign readdata    = q.rdData;
  assign waitrequest = q.waitReq;
  assign sampleValid = q.sampleValid;
  assign sample      = q.sample;
  assign traceDone   = q.traceDone;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  mode_gate_a: assert property (cycEdge && !q.cfg.extMode |=> !sampleValid) // RULE_15
    else $error("sample recorded outside extended mode");
  fetch_fail_a: assert property (cycEdge && isFetch && !fetchOk |=> !sampleValid) // RULE_02
    else $error("failing fetch recorded");
  mem_none_a: assert property ( // RULE_05
      cycEdge && (q.syn2.cycType inside {itq_pkg::ITQ_MEMRD, itq_pkg::ITQ_MEMWR}) &&
      q.cfg.memQual == itq_pkg::ITQ_MQ_OFF |=> !sampleValid)
    else $error("memory cycle recorded with qualifier off");
  read_only_a: assert property ( // RULE_04
      cycEdge && q.syn2.cycType == itq_pkg::ITQ_MEMWR &&
      q.cfg.memQual == itq_pkg::ITQ_MQ_RD |=> !sampleValid)
    else $error("write recorded with reads-only qualifier");
  io_off_a: assert property ( // RULE_06
      cycEdge && q.syn2.cycType == itq_pkg::ITQ_IO && !q.cfg.ioAll |=> !sampleValid)
    else $error("io cycle recorded with io qualifier off");
  range_in_a: assert property ( // RULE_09
      cycEdge && isFetch && q.cfg.rangeEn && a1 < a2 && ma > a2 |=> !sampleValid)
    else $error("address above window recorded");
  range_out_a: assert property ( // RULE_10
      cycEdge && isFetch && q.cfg.extMode && q.cfg.rangeEn && a1 > a2 && ma == a1 &&
      opOk && dataOk && probeOk && q.phase != itq_pkg::ITQ_PH_DONE &&
      !(write && !q.waitReq) |=> sampleValid)
    else $error("bound address not recorded in outside range");
  range_gap_a: assert property ( // RULE_10
      cycEdge && isFetch && q.cfg.rangeEn && a1 > a2 && ma > a2 && ma < a1
      |=> !sampleValid)
    else $error("address inside excluded gap recorded");
  addr_either_a: assert property ( // RULE_08
      cycEdge && isFetch && !q.cfg.rangeEn && ma != a1 && ma != a2
      |=> !sampleValid)
    else $error("fetch recorded with no address match");
  amask_sel_a: assert property ( // RULE_17
      cycEdge && isFetch && !q.cfg.rangeEn &&
      ((q.syn2.addr[15:0] ^ q.cfg.addr1[15:0]) & q.cfg.addrMask) != 16'h0000 &&
      ((q.syn2.addr[15:0] ^ q.cfg.addr2[15:0]) & q.cfg.addrMask) != 16'h0000 |=> !sampleValid)
    else $error("fetch recorded on masked address mismatch");
  wide_addr_a: assert property ( // RULE_07
      cycEdge && isFetch && q.cfg.ext8 && !q.cfg.rangeEn &&
      q.syn2.addr[23:16] != q.cfg.addr1[23:16] &&
      q.syn2.addr[23:16] != q.cfg.addr2[23:16] |=> !sampleValid)
    else $error("fetch recorded on extended address mismatch");
  data_mask_a: assert property ( // RULE_12
      cycEdge && isFetch && ((q.syn2.data ^ q.cfg.cmpWord) & q.cfg.cmpMask) != 16'h0000
      |=> !sampleValid)
    else $error("fetch recorded on masked data mismatch");
  mask_zero_a: assert property ( // RULE_13
      q.cfg.cmpMask == 16'h0000 |-> dataOk)
    else $error("zero data mask still rejects");
  opcode_gate_a: assert property ( // RULE_03
      cycEdge && isFetch && q.cfg.opcEn &&
      (q.syn2.data < q.cfg.opLo || q.syn2.data > q.cfg.opHi) |=> !sampleValid)
    else $error("fetch recorded outside opcode range");
  follow_idle_a: assert property ( // RULE_01
      cycEdge && !isFetch && q.phase != itq_pkg::ITQ_PH_FOLLOW |=> !sampleValid)
    else $error("cycle recorded without a qualified fetch");
  sample_addr_a: assert property ( // RULE_20
      cycEdge && isFetch && fetchOk && q.cfg.extMode && q.phase != itq_pkg::ITQ_PH_DONE &&
      !(write && !q.waitReq) |=> sampleValid && sample.addr == $past(q.syn2.addr) &&
      sample.extQual == $past(q.syn2.extQual))
    else $error("qualified fetch not recorded with its address");
  probe_open_a: assert property ( // RULE_14
      q.cfg.ext8 |-> probeOk && q.cfg.probeMask == 8'h00)
    else $error("probe check not forced open");
  count_stop_a: assert property ( // RULE_16
      sampleValid && q.cfg.countLim != 11'h000 && q.sampleCnt == q.cfg.countLim |-> traceDone)
    else $error("trace not stopped at count");
  done_hold_a: assert property ( // RULE_16
      q.phase == itq_pkg::ITQ_PH_DONE |=> !sampleValid)
    else $error("sample recorded after trace count reached");
  io_bits_a: assert property ( // RULE_18
      sampleValid && sample.cycType == itq_pkg::ITQ_IO |-> sample.data[15:2] == 14'h0000)
    else $error("io sample holds more than serial bits");
  io_sio_a: assert property ( // RULE_18
      sampleValid && sample.cycType == itq_pkg::ITQ_IO |->
      sample.data[1:0] == $past({q.syn2.sioOut, q.syn2.sioIn}))
    else $error("io sample serial bits wrong");
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not one cycle");
endmodule // itq_qualifier

//--- verif/itq_target_model.sv
// target bus model: fetch, memory and i/o cycles with probe byte
// assumes the qualifier synchronises tgtCycle over two clocks
`timescale 1ns/1ps
module itq_target_model (
  input  wire logic         ref_clk,
  output logic              tgtCycle,
  output itq_pkg::itq_bus_t tgtBus
);
  initial begin
    tgtCycle = 1'b0;
    tgtBus   = '0;
  end
  // bus valid 2 clocks before rise to 5 after; inverted otherwise
  task automatic cyc(input itq_pkg::itq_cyc_t t, input logic [23:0] a,
                     input logic [15:0] d, input logic [7:0] p);
    @(posedge ref_clk);
    tgtBus <= '{t, 8'hFF, a, d, p, 1'b1, 1'b0};
    repeat (2) @(posedge ref_clk);
    tgtCycle <= 1'b1;
    repeat (4) @(posedge ref_clk);
    tgtCycle <= 1'b0;
    @(posedge ref_clk);
    // stale bus must not look like a held value
    tgtBus <= itq_pkg::itq_bus_t'(~tgtBus);
    repeat (2) @(posedge ref_clk);
  endtask
endmodule // itq_target_model

//--- verif/itq_qualifier_tb.sv
// bench of the trace qualifier: avalon master, target model, sample monitor
// assumes the qualifier answers every register access with waitrequest low
`timescale 1ns/1ps
`include "itq_map.svh"
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module itq_qualifier_tb;
  localparam itq_pkg::itq_cyc_t cF = itq_pkg::ITQ_FETCH;
  localparam itq_pkg::itq_cyc_t cR = itq_pkg::ITQ_MEMRD;
  localparam itq_pkg::itq_cyc_t cW = itq_pkg::ITQ_MEMWR;
  localparam itq_pkg::itq_cyc_t cI = itq_pkg::ITQ_IO;
  logic                 ref_clk;
  logic                 rst;
  logic                 read;
  logic                 write;
  logic                 waitrequest;
  logic                 tgtCycle;
  logic                 sampleValid;
  logic                 traceDone;
  logic [5:0]           address;
  logic [31:0]          writedata;
  logic [3:0]           byteenable;
  logic [31:0]          readdata;
  logic [31:0]          rdv;
  itq_pkg::itq_bus_t    tgtBus;
  itq_pkg::itq_sample_t sample;
  itq_pkg::itq_sample_t lastS;
  int                   errors;
  int                   checks;
  int                   nSamp;
  itq_qualifier u_itq_qualifier (.ref_clk(ref_clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .tgtCycle(tgtCycle),
    .tgtBus(tgtBus), .sampleValid(sampleValid), .sample(sample),
    .traceDone(traceDone));
  itq_target_model u_itq_target_model (.ref_clk(ref_clk), .tgtCycle(tgtCycle),
    .tgtBus(tgtBus));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (sampleValid === 1'b1) begin
      nSamp++;
      lastS = sample;
    end
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address   <= a;
    writedata <= d;
    write     <= 1'b1;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    read    <= 1'b1;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask
  // ctrl last: its write restarts the count and phase
  task automatic cfg(input logic [31:0] c, input logic [23:0] a1, input logic [23:0] a2);
    wr(`ITQ_OFS_ADDR1, {8'h00, a1});
    wr(`ITQ_OFS_ADDR2, {8'h00, a2});
    wr(`ITQ_OFS_CTRL, c);
  endtask
  task automatic q(input itq_pkg::itq_cyc_t t, input logic [23:0] a,
                   input logic [15:0] d, input logic [7:0] p, input int e);
    int c0;
    c0 = nSamp;
    u_itq_target_model.cyc(t, a, d, p);
    `CHK("samples", e, nSamp - c0)
  endtask
  task t_reset;
    for (int i = 0; i <= 8; i++) begin
      rd(6'(i * 4), rdv);
      `CHK("reg", 32'h00000000, rdv)
    end
    rd(6'h3C, rdv);
    `CHK("unmapped", 32'h00000000, rdv)
    // only lane 1 may land; the other lanes keep their value
    byteenable <= 4'h2;
    wr(`ITQ_OFS_AMASK, 32'h0000AB55);
    byteenable <= 4'hF;
    rd(`ITQ_OFS_AMASK, rdv);
    `CHK("laneWrite", 32'h0000AB00, rdv)
    $display("test reset done");
  endtask
  task t_single;
    wr(`ITQ_OFS_AMASK, 32'h0000FFFF);
    cfg(32'h0000000C, 24'h000004, 24'h000004);
    q(cF, 24'h000004, 16'hA050, 8'h00, 0);
    cfg(32'h0000000D, 24'h000004, 24'h000004);
    q(cF, 24'h000004, 16'hA050, 8'h00, 1);
    `CHK("sample", {cF, 8'hFF, 24'h000004, 16'hA050}, lastS)
    q(cW, 24'h000022, 16'hFFFF, 8'h00, 1);
    q(cR, 24'h000022, 16'hFFFF, 8'h00, 0);
    q(cF, 24'h000005, 16'hA050, 8'h00, 0);
    q(cW, 24'h000022, 16'hFFFF, 8'h00, 0);
    wr(`ITQ_OFS_AMASK, 32'h0000FFF0);
    q(cF, 24'h000007, 16'hA050, 8'h00, 1);
    $display("test single done");
  endtask
  task t_memq;
    for (int m = 0; m < 4; m++) begin
      cfg(32'(1 + m * 4), 24'h000004, 24'h000004);
      q(cF, 24'h000004, 16'hA050, 8'h00, 1);
      q(cR, 24'h000030, 16'h1111, 8'h00, int'(m == 1 || m == 2));
      q(cW, 24'h000030, 16'h2222, 8'h00, int'(m == 1 || m == 3));
    end
    for (int i = 0; i < 2; i++) begin
      cfg(32'(1 + i * 16), 24'h000004, 24'h000004);
      q(cF, 24'h000004, 16'hA050, 8'h00, 1);
      q(cI, 24'h000012, 16'hFFFF, 8'h00, i);
    end
    `CHK("ioSample", {cI, 8'hFF, 24'h000012, 16'h0002}, lastS)
    $display("test qualifiers done");
  endtask
  task t_range;
    logic [23:0] ad [9] = '{24'h00000F, 24'h000010, 24'h000020, 24'h000021,
      24'h000010, 24'h000020, 24'h000015, 24'h000009, 24'h000021};
    int ex [9] = '{0, 1, 1, 0, 1, 1, 0, 1, 1};
    wr(`ITQ_OFS_AMASK, 32'h0000FFFF);
    cfg(32'h00000021, 24'h000010, 24'h000020);
    for (int k = 0; k < 9; k++) begin
      if (k == 4) cfg(32'h00000021, 24'h000020, 24'h000010);
      q(cF, ad[k], 16'hA050, 8'h00, ex[k]);
    end
    $display("test range done");
  endtask
  task t_data;
    wr(`ITQ_OFS_DCMP, 32'hFF001234);
    cfg(32'h00000001, 24'h000004, 24'h000004);
    q(cF, 24'h000004, 16'h12AB, 8'h00, 1);
    q(cF, 24'h000004, 16'h13AB, 8'h00, 0);
    wr(`ITQ_OFS_DCMP, 32'h00001234);
    q(cF, 24'h000004, 16'h13AB, 8'h00, 1);
    wr(`ITQ_OFS_OPRANGE, 32'hA060A050);
    cfg(32'h00000003, 24'h000004, 24'h000004);
    q(cF, 24'h000004, 16'hA050, 8'h00, 1);
    q(cF, 24'h000004, 16'hA060, 8'h00, 1);
    q(cF, 24'h000004, 16'hA061, 8'h00, 0);
    q(cF, 24'h000005, 16'hA055, 8'h00, 0);
    wr(`ITQ_OFS_PCMP, 32'h0000F05A);
    cfg(32'h00000001, 24'h000004, 24'h000004);
    q(cF, 24'h000004, 16'hA050, 8'h53, 1);
    q(cF, 24'h000004, 16'hA050, 8'h6A, 0);
    cfg(32'h00000041, 24'h120004, 24'h120004);
    wr(`ITQ_OFS_PCMP, 32'h0000F05A);
    rd(`ITQ_OFS_PCMP, rdv);
    `CHK("probeCfg", 32'h00000000, rdv)
    q(cF, 24'h120004, 16'hA050, 8'h6A, 1);
    q(cF, 24'h000004, 16'hA050, 8'h6A, 0);
    $display("test data done");
  endtask
  task t_count;
    wr(`ITQ_OFS_COUNT, 32'h00000002);
    cfg(32'h00000001, 24'h000004, 24'h000004);
    q(cF, 24'h000004, 16'hA050, 8'h00, 1);
    q(cF, 24'h000004, 16'hA050, 8'h00, 1);
    q(cF, 24'h000004, 16'hA050, 8'h00, 0);
    `CHK("done", 1'b1, traceDone)
    rd(`ITQ_OFS_STATUS, rdv);
    `CHK("status", 32'h00010002, rdv)
    wr(`ITQ_OFS_COUNT, 32'h00000000);
    cfg(32'h00000001, 24'h000004, 24'h000004);
    // done clears on the write edge itself; look one edge later
    @(posedge ref_clk);
    `CHK("done", 1'b0, traceDone)
    q(cF, 24'h000004, 16'hA050, 8'h00, 1);
    $display("test count done");
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    tally_and_finish;
  end
  initial begin
    {read, write, address, writedata} = '0;
    byteenable = 4'hF;
    rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    t_reset;
    t_single;
    t_memq;
    t_range;
    t_data;
    t_count;
    tally_and_finish;
  end
endmodule // itq_qualifier_tb
